// ===== rtl/hsr_pkg.sv
package hsr_pkg;

  // Bus address and command bytes.
  localparam logic [6:0] ADDR_SELF      = 7'h40;
  localparam logic [7:0] CMD_TEMP_HOLD  = 8'hE3;
  localparam logic [7:0] CMD_TEMP_POLL  = 8'hF3;

  // Core clock rate and conversion times in milliseconds.
  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned CONV14_MS     = 50;
  localparam int unsigned CONV13_MS     = 25;
  localparam int unsigned CONV12_MS     = 13;
  localparam int unsigned CONV11_MS     = 7;
  localparam int unsigned CONV14_CYC    = CONV14_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV13_CYC    = CONV13_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV12_CYC    = CONV12_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV11_CYC    = CONV11_MS * (CLK_HZ / 1000);

  // Resolution selector codes.
  localparam logic [1:0] RES_14         = 2'h0;
  localparam logic [1:0] RES_12         = 2'h1;
  localparam logic [1:0] RES_13         = 2'h2;
  localparam logic [1:0] RES_11         = 2'h3;

  localparam int unsigned CNT_W         = 22;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RECV  = 6'b000010,
    ST_ACK   = 6'b000100,
    ST_SEND  = 6'b001000,
    ST_MACK  = 6'b010000,
    ST_WAIT  = 6'b100000
  } hsr_state_t;

endpackage

// ===== rtl/hsr_conv_if.sv
`timescale 1ns/1ns
// Request and finish handshake between the serial engine and the conversion timer.
interface hsr_conv_if;
  logic       start;
  logic [1:0] res;
  logic       busy;
  logic       done;
  modport ctrl  (output start, output res, input busy, input done);
  modport timer (input start, input res, output busy, output done);
endinterface

// ===== rtl/hsr_conv_timer.sv
`timescale 1ns/1ns
// Counts out one temperature conversion at the selected resolution.
module hsr_conv_timer
  import hsr_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  hsr_conv_if.timer             conv,
  input  wire logic [CNT_W-1:0] t14_cyc,
  input  wire logic [CNT_W-1:0] t13_cyc,
  input  wire logic [CNT_W-1:0] t12_cyc,
  input  wire logic [CNT_W-1:0] t11_cyc
);
  logic [CNT_W-1:0] cnt_q;
  logic             busy_q;
  logic             done_q;
  logic [CNT_W-1:0] load_d;

  // Pick the maximum time for the requested resolution.
  always_comb begin
    case (conv.res)
      RES_14:  load_d = t14_cyc;
      RES_13:  load_d = t13_cyc;
      RES_12:  load_d = t12_cyc;
      default: load_d = t11_cyc;
    endcase
  end

  // The conversion finishes strictly before its maximum time.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (conv.start && !busy_q) begin
        cnt_q  <= load_d - CNT_W'(1);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= CNT_W'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - CNT_W'(1);
        end
      end
    end
  end

  assign conv.busy = busy_q;
  assign conv.done = done_q;
endmodule

// ===== rtl/hsr_sensor_link.sv
`timescale 1ns/1ns
module hsr_sensor_link
  import hsr_pkg::*;
#(
  parameter int unsigned T14_CYC = CONV14_CYC,
  parameter int unsigned T13_CYC = CONV13_CYC,
  parameter int unsigned T12_CYC = CONV12_CYC,
  parameter int unsigned T11_CYC = CONV11_CYC
)(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic [1:0]  res_sel,
  input  wire logic [15:0] temp_value,
  output logic             conv_busy
);
  hsr_conv_if conv ();

  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic       scl_p_q;
  logic       sda_p_q;
  hsr_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic       first_q;
  logic       rd_q;
  logic [1:0] byte_q;
  logic       hold_mode_q;
  logic       ready_q;
  logic [15:0] result_q;
  logic       start_q;
  logic       stretch_q;
  logic       sda_low_q;

  wire scl   = scl_s_q[1];
  wire sda   = sda_s_q[1];
  wire scl_r = scl & ~scl_p_q;
  wire scl_f = ~scl & scl_p_q;
  wire cond_s = scl & scl_p_q & sda_p_q & ~sda;
  wire cond_p = scl & scl_p_q & ~sda_p_q & sda;

  // Two-stage synchronisers for the pins; edges are only found past stage two.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  // Conversion timer with its handshake.
  hsr_conv_timer u_timer (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .conv     (conv),
    .t14_cyc  (CNT_W'(T14_CYC)),
    .t13_cyc  (CNT_W'(T13_CYC)),
    .t12_cyc  (CNT_W'(T12_CYC)),
    .t11_cyc  (CNT_W'(T11_CYC))
  );
  assign conv.res   = res_sel;
  assign conv.start = start_q;

  // Serial engine; outside ST_WAIT it advances only on detected edges, so a stopped clock just waits.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_IDLE;
      shift_q     <= 8'h00;
      bit_q       <= 4'h0;
      first_q     <= 1'b0;
      rd_q        <= 1'b0;
      byte_q      <= 2'h0;
      hold_mode_q <= 1'b0;
      ready_q     <= 1'b0;
      result_q    <= 16'h0000;
      start_q     <= 1'b0;
      stretch_q   <= 1'b0;
      sda_low_q   <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (conv.done) begin
        ready_q   <= 1'b1;
        result_q  <= {temp_value[15:2], 2'h0};
        stretch_q <= 1'b0;
      end
      if (cond_p) begin
        state_q   <= ST_IDLE;
        sda_low_q <= 1'b0;
      end else if (cond_s) begin
        state_q   <= ST_RECV;
        first_q   <= 1'b1;
        bit_q     <= 4'h0;
        sda_low_q <= 1'b0;
      end else begin
        case (state_q)
          ST_RECV: begin
            if (scl_r) begin
              shift_q <= {shift_q[6:0], sda};
              bit_q   <= bit_q + 4'h1;
            end else if (scl_f && bit_q == 4'h8) begin
              if (first_q) begin
                rd_q <= shift_q[0];
                if (shift_q[7:1] != ADDR_SELF) begin
                  state_q <= ST_IDLE;
                end else if (shift_q[0] && !ready_q) begin
                  state_q <= ST_IDLE;
                end else begin
                  sda_low_q <= 1'b1;
                  state_q   <= ST_ACK;
                end
              end else if (shift_q == CMD_TEMP_HOLD || shift_q == CMD_TEMP_POLL) begin
                hold_mode_q <= (shift_q == CMD_TEMP_HOLD);
                sda_low_q   <= 1'b1;
                state_q     <= ST_ACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_f) begin
              sda_low_q <= 1'b0;
              bit_q     <= 4'h0;
              if (first_q && rd_q) begin
                first_q   <= 1'b0;
                byte_q    <= 2'h0;
                sda_low_q <= ~result_q[15];
                shift_q   <= {result_q[14:8], 1'b0};
                ready_q   <= 1'b0;
                state_q   <= ST_SEND;
              end else if (first_q) begin
                first_q <= 1'b0;
                state_q <= ST_RECV;
              end else begin
                start_q <= 1'b1;
                ready_q <= 1'b0;
                if (hold_mode_q) begin
                  stretch_q <= 1'b1;
                  state_q   <= ST_WAIT;
                end else begin
                  state_q <= ST_IDLE;
                end
              end
            end
          end
          ST_WAIT: begin
            // Only the finished conversion can end the stretch; a read restart follows.
            if (!stretch_q && !conv.busy) begin
              state_q <= ST_IDLE;
            end
          end
          ST_SEND: begin
            if (scl_f) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                sda_low_q <= 1'b0;
                state_q   <= ST_MACK;
              end else begin
                sda_low_q <= ~shift_q[7];
                shift_q   <= {shift_q[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_r && sda) begin
              state_q <= ST_IDLE;
            end else if (scl_f) begin
              bit_q <= 4'h0;
              if (byte_q == 2'h0) begin
                byte_q    <= 2'h1;
                sda_low_q <= ~result_q[7];
                shift_q   <= {result_q[6:0], 1'b0};
                state_q   <= ST_SEND;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain drive; sda_o and scl_o stay zero and only the enables and conv_busy move.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o     <= 1'b0;
      sda_oe_n  <= 1'b1;
      scl_o     <= 1'b0;
      scl_oe_n  <= 1'b1;
      conv_busy <= 1'b0;
    end else begin
      sda_o     <= 1'b0;
      sda_oe_n  <= ~sda_low_q;
      scl_o     <= 1'b0;
      scl_oe_n  <= ~stretch_q;
      conv_busy <= conv.busy;
    end
  end
endmodule

// ===== verification/hsr_properties.sv
`timescale 1ns/1ns
// Pin checks of the sensor link; the conversion limits follow the bound instance.
module hsr_prop
  import hsr_pkg::*;
#(
  parameter int unsigned T14_CYC = 200,
  parameter int unsigned T13_CYC = 100,
  parameter int unsigned T12_CYC = 60,
  parameter int unsigned T11_CYC = 30
)(
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n,
  input wire logic       scl_o,
  input wire logic       scl_oe_n,
  input wire logic [1:0] res_sel,
  input wire logic       conv_busy
);
  int unsigned cnt_q;
  int unsigned hold_q;
  int unsigned lim_q;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Run lengths of conversion and stretch; the limit only moves while idle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
      hold_q <= 0;
      lim_q <= T14_CYC;
    end else begin
      cnt_q <= conv_busy ? cnt_q + 1 : 0;
      hold_q <= scl_oe_n ? 0 : hold_q + 1;
      if (!conv_busy) lim_q <= (res_sel == RES_11) ? T11_CYC : (res_sel == RES_12) ? T12_CYC :
                               (res_sel == RES_13) ? T13_CYC : T14_CYC;
    end
  end
  sda_low_only_a: assert property (sda_o == 1'h0)
    else $error("Data pin driven high");
  scl_low_only_a: assert property (scl_o == 1'h0)
    else $error("Clock pin driven high");
  read_bit_hold_a: assert property (scl_i [*4] |-> $stable(sda_oe_n))
    else $error("Data moved while clock high");
  conv_time_a: assert property (conv_busy |-> cnt_q < lim_q)
    else $error("Conversion overran its limit");
  stretch_in_conv_a: assert property ($fell(scl_oe_n) |-> ##[0:2] conv_busy)
    else $error("Stretch without conversion");
  stretch_release_a: assert property ($fell(conv_busy) |-> ##[0:2] scl_oe_n)
    else $error("Stretch kept after conversion");
  // The stretch leads the busy flag by one cycle, so idle is judged one sample back.
  no_idle_stretch_a: assert property (!conv_busy [*4] |-> $past(scl_oe_n))
    else $error("Clock held while idle");
  stretch_len_a: assert property (!scl_oe_n |-> hold_q < lim_q + 3)
    else $error("Stretch too long");
endmodule
bind hsr_sensor_link hsr_prop #(.T14_CYC(T14_CYC), .T13_CYC(T13_CYC), .T12_CYC(T12_CYC),
  .T11_CYC(T11_CYC)) hsr_prop_inst (.core_clk(core_clk), .arst_n(arst_n), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .res_sel(res_sel),
  .conv_busy(conv_busy));

// ===== verification/hsr_bfm.sv
`timescale 1ns/1ns
// Bus controller; clock phases of 4 core cycles plus slow give a 160 ns serial clock while slow is 0.
module hsr_bfm (
  input  wire logic core_clk,
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_drv,
  output logic      sda_drv
);
  int slow = 0;
  int stretch_n;
  bit tmo = 0;
  // Both lines start released so the pull-ups hold the bus idle.
  initial begin
    scl_drv = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic idle(input int n);
    repeat (n + slow) @(posedge core_clk);
  endtask
  // Releases the clock and waits, bounded, while the sensor holds it low.
  task automatic rise();
    scl_drv <= 1'h1;
    @(posedge core_clk);
    for (stretch_n = 0; !scl_w && stretch_n < 400; stretch_n++) @(posedge core_clk);
    if (!scl_w) tmo = 1'h1;
  endtask
  task automatic start();
    @(posedge core_clk);
    sda_drv <= 1'h1;
    idle(7);
    rise();
    idle(4);
    sda_drv <= 1'h0;
    idle(4);
    scl_drv <= 1'h0;
  endtask
  task automatic stop();
    @(posedge core_clk);
    sda_drv <= 1'h0;
    idle(3);
    rise();
    idle(4);
    sda_drv <= 1'h1;
  endtask
  // Data moves one cycle after the fall and holds through the high phase.
  task automatic bit_io(input logic b, output logic r);
    @(posedge core_clk);
    sda_drv <= b;
    idle(3);
    rise();
    idle(2);
    r = sda_w;
    @(posedge core_clk);
    scl_drv <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask
  task automatic rd(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      v[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  import hsr_pkg::*;
  localparam int unsigned T14 = 200;
  localparam int unsigned T13 = 100;
  localparam int unsigned T12 = 60;
  localparam int unsigned T11 = 30;
  logic        core_clk;
  logic        arst_n;
  logic [1:0]  res_sel;
  logic [15:0] temp_value;
  wire         sda_o, sda_oe_n, scl_o, scl_oe_n, conv_busy, scl_drv, sda_drv;
  int          error_cnt = 0;
  int          check_count = 0;
  logic        a;
  logic [7:0]  hi, lo;
  // Open-drain wires with pull-ups: whoever pulls low wins.
  wire scl_w = scl_drv & (scl_oe_n | scl_o);
  wire sda_w = sda_drv & (sda_oe_n | sda_o);
  hsr_sensor_link #(.T14_CYC(T14), .T13_CYC(T13), .T12_CYC(T12), .T11_CYC(T11))
    hsr_sensor_link_inst (.core_clk(core_clk), .arst_n(arst_n), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .res_sel(res_sel),
    .temp_value(temp_value), .conv_busy(conv_busy));
  hsr_bfm hsr_bfm_inst (.core_clk(core_clk), .scl_w(scl_w), .sda_w(sda_w), .scl_drv(scl_drv),
    .sda_drv(sda_drv));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (hsr_bfm_inst.tmo) error_cnt++;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read header, both result bytes, stop; status bits come back as zero.
  task automatic read_out(input logic [15:0] v);
    hsr_bfm_inst.wr({ADDR_SELF, 1'h1}, a);
    check(a, 1'h1);
    hsr_bfm_inst.rd(1'h0, hi);
    hsr_bfm_inst.rd(1'h1, lo);
    hsr_bfm_inst.stop();
    check({hi, lo}, v & 16'hFFFC);
  endtask
  task automatic hold_read(input logic [1:0] res, input int lim, input logic [15:0] v);
    @(posedge core_clk);
    res_sel <= res;
    temp_value <= v;
    hsr_bfm_inst.start();
    hsr_bfm_inst.wr({ADDR_SELF, 1'h0}, a);
    check(a, 1'h1);
    hsr_bfm_inst.wr(CMD_TEMP_HOLD, a);
    check(a, 1'h1);
    hsr_bfm_inst.start();
    check(hsr_bfm_inst.stretch_n inside {[1:lim]}, 1'h1);
    read_out(v);
    $display("Held conversion, resolution code %0d, done", res);
  endtask
  task automatic refused();
    hsr_bfm_inst.start();
    hsr_bfm_inst.wr({ADDR_SELF + 7'h01, 1'h0}, a);
    check(a, 1'h0);
    hsr_bfm_inst.stop();
    hsr_bfm_inst.start();
    hsr_bfm_inst.wr({ADDR_SELF, 1'h0}, a);
    hsr_bfm_inst.wr(8'hE5, a);
    check(a, 1'h0);
    hsr_bfm_inst.stop();
    $display("Refused address and command done");
  endtask
  // Early poll is refused; after the maximum time a slowed clock reads the result.
  task automatic polled(input logic [15:0] v);
    @(posedge core_clk);
    res_sel <= RES_14;
    temp_value <= v;
    hsr_bfm_inst.start();
    hsr_bfm_inst.wr({ADDR_SELF, 1'h0}, a);
    hsr_bfm_inst.wr(CMD_TEMP_POLL, a);
    check(a, 1'h1);
    hsr_bfm_inst.stop();
    hsr_bfm_inst.start();
    hsr_bfm_inst.wr({ADDR_SELF, 1'h1}, a);
    check(a, 1'h0);
    hsr_bfm_inst.stop();
    repeat (T14) @(posedge core_clk);
    hsr_bfm_inst.slow = 40;
    hsr_bfm_inst.start();
    read_out(v);
    hsr_bfm_inst.slow = 0;
    $display("Polled conversion done");
  endtask
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    arst_n = 1'h0;
    res_sel = RES_14;
    temp_value = 16'h0000;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    hold_read(RES_14, T14, 16'h7C83);
    hold_read(RES_13, T13, 16'hA5A6);
    hold_read(RES_12, T12, 16'h0001);
    hold_read(RES_11, T11, 16'hFFFF);
    refused();
    polled(16'h5A5C);
    wrap_up();
  end
  // A clock stretched past its bound ends the run at once.
  always @(posedge hsr_bfm_inst.tmo) wrap_up();
endmodule
